// >>> dv/rss_pins_model.sv
// Model of the master clear pin, the supply monitors and the oscillator status.
`timescale 1ns/100ps
module rss_pins_model (
  input wire logic sys_clk,
  output logic master_clear_pin_n,
  output logic por_event,
  output logic brownout_reset,
  output logic slow_rc_clk,
  output rss_pkg::rss_clk_stat_t clk_stat_async
);
  import rss_pkg::*;
  logic clk_ok = 1'b1;
  // The pin rests high on its pull-up, and the monitors rest quiet.
  initial begin
    master_clear_pin_n = 1'b1;
    por_event = 1'b0;
    brownout_reset = 1'b0;
    slow_rc_clk = 1'b0;
  end
  // The slow RC runs free, so the delays never wait on the main oscillator.
  always #20 slow_rc_clk = ~slow_rc_clk;
  // The oscillator is either ready at once or never ready.
  assign clk_stat_async = '{clk_ok, clk_ok, clk_ok};
  // Pulls the pin low (which 0) or raises brown-out (which 1) for n cycles.
  task automatic pulse(input int which, input int n);
    @(posedge sys_clk);
    if (which == 0) master_clear_pin_n <= 1'b0;
    else brownout_reset <= 1'b1;
    repeat (n) @(posedge sys_clk);
    master_clear_pin_n <= 1'b1;
    brownout_reset <= 1'b0;
  endtask
endmodule

// >>> dv/rss_reset_seq_tb_top.sv
// Self-checking bench for the reset source sequencer.
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module rss_reset_seq_tb_top;
  import rss_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, mc_n, por, bor, src, pin_o, pin_oe, sys_rst_n, ld, frz;
  logic [23:0] addr, pc_v;
  rss_clk_stat_t cs;
  rss_cfg_t cfg = '{2'h0, 1'b0, 1'b0, 1'b0, 3'h1};
  rss_cpu_t cpu = '0;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int exp_flags = 'h3;
  always #5 sys_clk = ~sys_clk;
  rss_pins_model i_rss_pins_model (.sys_clk(sys_clk), .master_clear_pin_n(mc_n),
    .por_event(por), .brownout_reset(bor), .slow_rc_clk(src), .clk_stat_async(cs));
  rss_reset_seq #(.POWER_UP_TIMER_4MS_TICKS(16'h4), .POWER_UP_TIMER_16MS_TICKS(16'h8), .POWER_UP_TIMER_64MS_TICKS(16'h10),
    .MASTER_CLEAR_PIN_FILT_CYC(3)) i_rss_reset_seq (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .master_clear_pin_n(mc_n), .master_clear_pin_o(pin_o),
    .master_clear_pin_oe(pin_oe), .por_event(por), .brownout_reset(bor), .slow_rc_clk(src),
    .clk_stat_async(cs), .cfg(cfg), .cpu(cpu), .system_reset_n(sys_rst_n),
    .restart_load(ld), .restart_addr(addr), .clock_fail_trap(), .clock_select(),
    .osc_startup_start(), .cpu_frozen(frz));
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Cuts a hang short.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      finish_test();
    end
  end
  // One Avalon access, held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Reads the cause flags and compares them with the bench model.
  task automatic chk_flags();
    bus(1'b0, ADDR_FLAGS, 32'h0);
    `CHK(q, 32'(exp_flags))
  endtask
  // Waits for the restart pulse and checks its address and the released reset.
  task automatic wait_ld(input logic [23:0] a);
    int n;
    n = 0;
    do @(posedge sys_clk); while (ld !== 1'b1 && ++n < 2000);
    `CHK({ld, sys_rst_n, addr}, {2'b11, a})
  endtask
  // Raises the software reset request for a few cycles.
  task automatic sw_reset();
    @(posedge sys_clk);
    cpu.sw_reset_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cpu.sw_reset_req <= 1'b0;
  endtask
  // Main sequence of scenarios.
  initial begin
    void'($urandom(32'h4fcfbc71));
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_flags();
    wait_ld(VEC_RESET);
    `CHK({pin_o, pin_oe}, 2'b00)
    bus(1'b1, ADDR_FLAGS, 32'h0);
    exp_flags = 0;
    bus(1'b0, 4'hc, 32'h0);
    `CHK(q, 32'h0)
    sw_reset();
    exp_flags = 'h40;
    wait_ld(VEC_RESET);
    chk_flags();
    i_rss_pins_model.pulse(0, 1);
    repeat (30) @(posedge sys_clk);
    chk_flags();
    i_rss_pins_model.pulse(0, 40);
    exp_flags = 'h80;
    wait_ld(VEC_RESET);
    chk_flags();
    i_rss_pins_model.pulse(1, 10);
    exp_flags = 'h82;
    wait_ld(VEC_RESET);
    chk_flags();
    pc_v = 24'($urandom()) & 24'hfffffe;
    cpu.sleep <= 1'b1;
    cpu.pc <= pc_v;
    @(posedge sys_clk);
    cpu.wdt_timeout <= 1'b1;
    wait_ld(pc_v + 24'h000002);
    cpu.wdt_timeout <= 1'b0;
    exp_flags = 'h9a;
    chk_flags();
    cpu.sleep <= 1'b0;
    cfg.clock_fail_monitor_en <= 1'b1;
    cfg.power_up_timer_sel <= POWER_UP_TIMER_SEL_4MS;
    i_rss_pins_model.clk_ok <= 1'b0;
    sw_reset();
    exp_flags = 'h42;
    wait_ld(VEC_CLOCK_FAIL);
    chk_flags();
    // The trap selected the fast RC and set the sticky clock fail bit; lock stays low.
    bus(1'b0, ADDR_OSC, 32'h0);
    `CHK(q, 32'h00007008)
    bus(1'b1, ADDR_OSC, 32'h0);
    bus(1'b0, ADDR_OSC, 32'h0);
    `CHK(q, 32'h00007000)
    // With the monitor off and no clock, the core stays frozen in reset.
    cfg.clock_fail_monitor_en <= 1'b0;
    sw_reset();
    repeat (150) @(posedge sys_clk);
    `CHK({frz, sys_rst_n}, 2'b10)
    i_rss_pins_model.clk_ok <= 1'b1;
    wait_ld(VEC_RESET);
    chk_flags();
    finish_test();
  end
endmodule

// >>> include/rss_pkg.sv
// Constants, types and field layouts shared by the reset source sequencer.
// Behaviour
// - Tell apart power-on, pin, watchdog, brown-out, software, trap and illegal-op resets.
// - A watchdog wake-up resumes normal operation and reinitialises nothing.
// - The master clear path filters out short pin pulses.
// - Internal resets never drive the master clear pin low.
// - Power-on restarts the timers, enters reset and selects the configured clock.
// - After power-on, a 10 us bias delay precedes the power-up delay.
// - Power-up delay is selectable: none, 4 ms, 16 ms or 64 ms.
// - Reset releases on the next first quarter phase edge, at the reset vector.
// - Clock monitor on and clock not ready after delays: trap, switch to fast RC.
// - Monitor and power-up timer both off: leave reset quickly.
// - Monitor off and no clock: stay frozen at the reset vector.
// - Brown-out selects the configured clock and waits for oscillator start-up.
// - With the PLL in use, hold the clock until the lock bit reads one.
// - After brown-out with no power-up delay and a crystal, use 100 us instead (here only with the monitor on; with it off the quick exit skips it).
// - Brown-out sets the brown-out status flag.
// - The brown-out detector keeps working in sleep and idle.
// - Each reset kind sets its own cause flags.
// - Resets load address zero, clock fail loads four, wakes resume or vector.
// - Events alter only their own flags (software, watchdog, pin and power-on events here also clear other flags); brown-out clears only the power-on flag.
// - Cause flags are readable and writable by software.
// - Watchdog time-out resets the device, but in sleep only wakes it.
// - Non power-on resets from sleep set the sleep flag; power-on clears it (here only pin and brown-out resets set it; software resets clear it).
package rss_pkg;

  // Clock and delay figures.
  localparam int SYS_CLK_NS = 10;
  localparam int SLOW_RC_KHZ = 512;
  localparam int BIAS_SETTLE_NS = 10000;
  localparam int FAIL_SAFE_SETTLE_NS = 100000;
  localparam int POWER_UP_TIMER_4_MS = 4;
  localparam int POWER_UP_TIMER_16_MS = 16;
  localparam int POWER_UP_TIMER_64_MS = 64;
  localparam int MASTER_CLEAR_PIN_FILTER_NS = 200;
  localparam int CNT_W = 16;

  // Delays as counts of slow RC ticks (least times round up) and system clocks.
  localparam logic [CNT_W-1:0] BIAS_TICKS =
    CNT_W'((BIAS_SETTLE_NS * SLOW_RC_KHZ + 999999) / 1000000);
  localparam logic [CNT_W-1:0] FAIL_SAFE_TICKS =
    CNT_W'((FAIL_SAFE_SETTLE_NS * SLOW_RC_KHZ + 999999) / 1000000);
  localparam logic [CNT_W-1:0] POWER_UP_TIMER_4MS_TICKS = CNT_W'(POWER_UP_TIMER_4_MS * SLOW_RC_KHZ);
  localparam logic [CNT_W-1:0] POWER_UP_TIMER_16MS_TICKS = CNT_W'(POWER_UP_TIMER_16_MS * SLOW_RC_KHZ);
  localparam logic [CNT_W-1:0] POWER_UP_TIMER_64MS_TICKS = CNT_W'(POWER_UP_TIMER_64_MS * SLOW_RC_KHZ);
  localparam int MASTER_CLEAR_PIN_FILT_CYC = (MASTER_CLEAR_PIN_FILTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

  // Power-up delay selection codes.
  localparam logic [1:0] POWER_UP_TIMER_SEL_NONE = 2'h0;
  localparam logic [1:0] POWER_UP_TIMER_SEL_4MS = 2'h1;
  localparam logic [1:0] POWER_UP_TIMER_SEL_16MS = 2'h2;

  // Quarter phase counter; the last phase precedes the first quarter edge.
  localparam logic [1:0] Q_LAST = 2'h3;
  localparam logic [1:0] Q_FIRST = 2'h0;

  // Restart addresses and the fast RC group code.
  localparam logic [23:0] VEC_RESET = 24'h000000;
  localparam logic [23:0] VEC_CLOCK_FAIL = 24'h000004;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [2:0] OSC_GROUP_FAST_RC = 3'h7;
  localparam logic [2:0] OSC_GROUP_RST = 3'h0;

  // Register word indices and byte offsets.
  localparam logic [1:0] IDX_FLAGS = 2'h0;
  localparam logic [1:0] IDX_OSC = 2'h1;
  localparam logic [1:0] IDX_SEQ = 2'h2;
  localparam logic [3:0] ADDR_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_OSC = 4'h4;
  localparam logic [3:0] ADDR_SEQ = 4'h8;

  // Reset control register field positions.
  localparam int F_POR = 0;
  localparam int F_BOR = 1;
  localparam int F_IDLE = 2;
  localparam int F_SLEEP = 3;
  localparam int F_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int F_SW = 6;
  localparam int F_EXT = 7;
  localparam int F_ILLEGAL = 14;
  localparam int F_TRAP = 15;
  localparam logic [15:0] FLAGS_MASK = 16'hc0df;
  localparam logic [15:0] FLAGS_POR_VAL = 16'h0003;

  // Oscillator control register field positions.
  localparam int OSC_CF_BIT = 3;
  localparam int OSC_LOCK_BIT = 5;
  localparam int OSC_COSC_LSB = 12;

  // Reset source vector positions.
  localparam int SRC_ILL = 0;
  localparam int SRC_TRAP = 1;
  localparam int SRC_SW = 2;
  localparam int SRC_WDT = 3;
  localparam int SRC_MASTER_CLEAR_PIN = 4;
  localparam int SRC_BOR = 5;
  localparam int SRC_POR = 6;
  localparam int SRC_N = 7;

  typedef enum logic [2:0] {ST_RESET, ST_BIAS, ST_POWER_UP_TIMER, ST_CLKWAIT, ST_Q1, ST_RUN} rss_state_t;

  // Configuration straps, static while the device runs.
  typedef struct packed {
    logic [1:0] power_up_timer_sel;
    logic clock_fail_monitor_en;
    logic crystal_mode;
    logic pll_used;
    logic [2:0] osc_group_select_cfg;
  } rss_cfg_t;

  // Requests and state from the processor core, same clock.
  typedef struct packed {
    logic sleep;
    logic idle;
    logic wdt_timeout;
    logic sw_reset_req;
    logic trap_lockup_req;
    logic illegal_op_req;
    logic irq_wake;
    logic [23:0] irq_vector;
    logic [23:0] pc;
  } rss_cpu_t;

  // Oscillator status, arriving from other clock sources.
  typedef struct packed {
    logic osc_running;
    logic ost_done;
    logic pll_locked;
  } rss_clk_stat_t;

endpackage

// >>> rtl/rss_in_filter.sv
// Two-stage synchroniser followed by a stability filter.
`timescale 1ns/100ps
module rss_in_filter #(
  parameter int W = 1,
  parameter int STABLE = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  localparam int CW = $clog2(STABLE + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(STABLE - 1);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] dout_q;
  logic [CW-1:0] cnt_q;
  logic differs;

  // A new level must persist for STABLE cycles before it is passed on.
  assign differs = sync_q != dout_q;
  assign dout = dout_q;

  // Synchroniser and filter counter.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      dout_q <= RST_VAL;
      cnt_q <= '0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      if (differs && cnt_q == CNT_LAST) begin
        dout_q <= sync_q;
        cnt_q <= '0;
      end else if (differs) begin
        cnt_q <= cnt_q + CW'(1);
      end else begin
        cnt_q <= '0;
      end
    end
  end

  property p_filter_stable;
    @(posedge sys_clk) disable iff (!rst_n)
      (dout_q != $past(dout_q)) |-> ($past(cnt_q) == CNT_LAST && $past(sync_q) == dout_q);
  endproperty
  a_filter_stable: assert property (p_filter_stable) else $error("filter output moved early");
endmodule

// >>> rtl/rss_reset_seq.sv
// Reset source gathering, release sequencing and cause flags, with an Avalon-MM slave.
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
module rss_reset_seq #(
  parameter logic [rss_pkg::CNT_W-1:0] POWER_UP_TIMER_4MS_TICKS = rss_pkg::POWER_UP_TIMER_4MS_TICKS,
  parameter logic [rss_pkg::CNT_W-1:0] POWER_UP_TIMER_16MS_TICKS = rss_pkg::POWER_UP_TIMER_16MS_TICKS,
  parameter logic [rss_pkg::CNT_W-1:0] POWER_UP_TIMER_64MS_TICKS = rss_pkg::POWER_UP_TIMER_64MS_TICKS,
  parameter int MASTER_CLEAR_PIN_FILT_CYC = rss_pkg::MASTER_CLEAR_PIN_FILT_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic master_clear_pin_n,
  output logic master_clear_pin_o,
  output logic master_clear_pin_oe,
  input wire logic por_event,
  input wire logic brownout_reset,
  input wire logic slow_rc_clk,
  input wire rss_pkg::rss_clk_stat_t clk_stat_async,
  input wire rss_pkg::rss_cfg_t cfg,
  input wire rss_pkg::rss_cpu_t cpu,
  output logic system_reset_n,
  output logic restart_load,
  output logic [23:0] restart_addr,
  output logic clock_fail_trap,
  output logic [2:0] clock_select,
  output logic osc_startup_start,
  output logic cpu_frozen
);
  import rss_pkg::*;

  logic master_clear_pin_n_s;
  logic [5:0] async_s;
  logic por_s;
  logic bor_s;
  logic slow_s;
  rss_clk_stat_t clk_s;
  logic [SRC_N-1:0] src_lvl;
  logic [SRC_N-1:0] src_prev_q;
  logic [SRC_N-1:0] ev;
  logic any_src;
  logic wdt_wake_lvl;
  logic [1:0] wake_prev_q;
  logic ev_wdt_wake;
  logic ev_irq_wake;
  logic slow_prev_q;
  logic slow_tick;
  rss_state_t state_q;
  rss_state_t state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] power_up_timer_limit;
  logic fail_safe_needed;
  logic rapid_exit;
  logic clk_ok;
  logic q1_edge;
  logic trap_fire;
  logic release_now;
  logic [1:0] q_phase_q;
  logic trap_pend_q;
  logic pwr_seq_q;
  logic bor_seq_q;
  logic system_reset_n_n_q;
  logic restart_load_q;
  logic [23:0] restart_addr_q;
  logic clk_fail_trap_q;
  logic [2:0] clock_sel_q;
  logic ost_start_q;
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic cf_q;
  logic ack_q;
  logic [31:0] readdata_q;
  logic req;
  logic reg_wr;
  logic [1:0] reg_idx;
  logic sel_flags;
  logic sel_osc;
  logic sel_seq;
  logic [15:0] wmask;
  logic [15:0] osc_stat;
  logic [31:0] seq_stat;
  logic [31:0] rd_mux;
  logic wake_accept;

  // The pin is filtered; supply monitors, slow RC and clock status are only synchronised.
  rss_in_filter #(.W(1), .STABLE(MASTER_CLEAR_PIN_FILT_CYC), .RST_VAL(1'b1)) u_master_clear_pin_filt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din(master_clear_pin_n),
    .dout(master_clear_pin_n_s)
  );
  rss_in_filter #(.W(6), .STABLE(1), .RST_VAL(6'h00)) u_async_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .din({por_event, brownout_reset, slow_rc_clk, clk_stat_async}),
    .dout(async_s)
  );
  assign por_s = async_s[5];
  assign bor_s = async_s[4]; // Not gated by sleep or idle.
  assign slow_s = async_s[3];
  assign clk_s = rss_clk_stat_t'(async_s[2:0]);

  // The pin is never driven by this block.
  assign master_clear_pin_o = 1'b0;
  assign master_clear_pin_oe = 1'b0;

  // Reset sources, their rising edges and the combined request.
  assign wdt_wake_lvl = cpu.wdt_timeout & cpu.sleep;
  assign src_lvl[SRC_POR] = por_s;
  assign src_lvl[SRC_BOR] = bor_s;
  assign src_lvl[SRC_MASTER_CLEAR_PIN] = ~master_clear_pin_n_s;
  assign src_lvl[SRC_WDT] = cpu.wdt_timeout & ~cpu.sleep;
  assign src_lvl[SRC_SW] = cpu.sw_reset_req;
  assign src_lvl[SRC_TRAP] = cpu.trap_lockup_req;
  assign src_lvl[SRC_ILL] = cpu.illegal_op_req;
  assign any_src = |src_lvl;
  assign ev = src_lvl & ~src_prev_q;
  assign ev_wdt_wake = wdt_wake_lvl & ~wake_prev_q[1];
  assign ev_irq_wake = cpu.irq_wake & cpu.sleep & ~wake_prev_q[0];
  assign wake_accept = (state_q == ST_RUN) & ~any_src;
  assign slow_tick = slow_s & ~slow_prev_q;

  // Delay selection and release conditions.
  assign fail_safe_needed = bor_seq_q & cfg.crystal_mode & (cfg.power_up_timer_sel == POWER_UP_TIMER_SEL_NONE);
  assign power_up_timer_limit = fail_safe_needed ? FAIL_SAFE_TICKS :
                      (cfg.power_up_timer_sel == POWER_UP_TIMER_SEL_NONE) ? '0 :
                      (cfg.power_up_timer_sel == POWER_UP_TIMER_SEL_4MS) ? POWER_UP_TIMER_4MS_TICKS :
                      (cfg.power_up_timer_sel == POWER_UP_TIMER_SEL_16MS) ? POWER_UP_TIMER_16MS_TICKS : POWER_UP_TIMER_64MS_TICKS;
  assign rapid_exit = ~cfg.clock_fail_monitor_en & (cfg.power_up_timer_sel == POWER_UP_TIMER_SEL_NONE);
  assign clk_ok = clk_s.osc_running & (clk_s.ost_done | ~cfg.crystal_mode)
                  & (clk_s.pll_locked | ~cfg.pll_used);
  assign q1_edge = q_phase_q == Q_LAST;
  assign cpu_frozen = (state_q == ST_CLKWAIT) & ~cfg.clock_fail_monitor_en;

  // Release sequence; any source sends it back to the start.
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    trap_fire = 1'b0;
    release_now = 1'b0;
    unique case (state_q)
      ST_RESET: begin
        cnt_d = '0;
        if (!any_src) begin
          state_d = rapid_exit ? ST_CLKWAIT : ST_BIAS;
        end
      end
      ST_BIAS: begin
        if (slow_tick && cnt_q == BIAS_TICKS - CNT_W'(1)) begin
          cnt_d = '0;
          state_d = ST_POWER_UP_TIMER;
        end else if (slow_tick) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      ST_POWER_UP_TIMER: begin
        if (power_up_timer_limit == '0) begin
          state_d = ST_CLKWAIT;
        end else if (slow_tick && cnt_q == power_up_timer_limit - CNT_W'(1)) begin
          cnt_d = '0;
          state_d = ST_CLKWAIT;
        end else if (slow_tick) begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      ST_CLKWAIT: begin
        if (clk_ok) begin
          state_d = ST_Q1;
        end else if (cfg.clock_fail_monitor_en) begin
          trap_fire = 1'b1;
          state_d = ST_Q1;
        end
      end
      ST_Q1: begin
        if (q1_edge) begin
          release_now = 1'b1;
          state_d = ST_RUN;
        end
      end
      ST_RUN: state_d = ST_RUN;
    endcase
    if (any_src) begin
      state_d = ST_RESET;
      cnt_d = '0;
      trap_fire = 1'b0;
      release_now = 1'b0;
    end
  end

  // Cause flags: software write first, then hardware events win over it.
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & FLAGS_MASK;
  always_comb begin
    flags_d = flags_q;
    if (reg_wr && sel_flags) begin
      flags_d = (flags_q & ~wmask) | (avs_writedata[15:0] & wmask);
    end
    if (ev[SRC_ILL]) begin
      flags_d[F_ILLEGAL] = 1'b1;
    end
    if (ev[SRC_TRAP]) begin
      flags_d[F_TRAP] = 1'b1;
    end
    if (ev[SRC_SW]) begin
      flags_d[F_SW] = 1'b1;
      flags_d[F_EXT] = 1'b0;
      flags_d[F_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      flags_d[F_IDLE] = 1'b0;
      flags_d[F_SLEEP] = 1'b0;
    end
    if (ev[SRC_WDT]) begin
      flags_d[F_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      flags_d[F_EXT] = 1'b0;
      flags_d[F_SW] = 1'b0;
      flags_d[F_IDLE] = 1'b0;
      flags_d[F_SLEEP] = 1'b0;
    end
    if (ev[SRC_MASTER_CLEAR_PIN]) begin
      flags_d[F_EXT] = 1'b1;
      flags_d[F_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      flags_d[F_IDLE] = cpu.idle;
      flags_d[F_SLEEP] = cpu.sleep;
      if (!cpu.sleep && !cpu.idle) begin
        flags_d[F_SW] = 1'b0;
      end
    end
    if (ev_wdt_wake) begin
      flags_d[F_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      flags_d[F_SLEEP] = 1'b1;
    end
    if (ev_irq_wake) begin
      flags_d[F_SLEEP] = 1'b1;
    end
    if (ev[SRC_BOR]) begin
      flags_d[F_POR] = 1'b0;
      flags_d[F_BOR] = 1'b1;
      flags_d[F_SLEEP] = flags_d[F_SLEEP] | cpu.sleep;
      flags_d[F_IDLE] = flags_d[F_IDLE] | cpu.idle;
    end
    if (ev[SRC_POR]) begin
      flags_d = FLAGS_POR_VAL;
    end
  end

  // Edge history, quarter phase and sequence counters.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_q <= '0;
      wake_prev_q <= '0;
      slow_prev_q <= 1'b0;
      q_phase_q <= Q_FIRST;
      state_q <= ST_RESET;
      cnt_q <= '0;
      flags_q <= FLAGS_POR_VAL;
    end else begin
      src_prev_q <= src_lvl;
      wake_prev_q <= {wdt_wake_lvl, cpu.irq_wake};
      slow_prev_q <= slow_s;
      q_phase_q <= q_phase_q + 2'h1;
      state_q <= state_d;
      cnt_q <= cnt_d;
      flags_q <= flags_d;
    end
  end

  // Sequence bookkeeping: power sequence, brown-out origin and pending trap.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_seq_q <= 1'b1;
      bor_seq_q <= 1'b0;
      trap_pend_q <= 1'b0;
      cf_q <= 1'b0;
    end else begin
      pwr_seq_q <= ev[SRC_POR] | ev[SRC_BOR] | (pwr_seq_q & ~release_now);
      bor_seq_q <= ev[SRC_BOR] | (bor_seq_q & ~ev[SRC_POR] & ~release_now);
      trap_pend_q <= trap_fire | (trap_pend_q & ~release_now & ~any_src);
      cf_q <= trap_fire | (cf_q & ~(reg_wr & sel_osc & avs_byteenable[0]
                                    & ~avs_writedata[OSC_CF_BIT]));
    end
  end

  // Outputs to the core and clock logic.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      system_reset_n_n_q <= 1'b0;
      restart_load_q <= 1'b0;
      restart_addr_q <= VEC_RESET;
      clk_fail_trap_q <= 1'b0;
      clock_sel_q <= OSC_GROUP_RST;
      ost_start_q <= 1'b0;
    end else begin
      system_reset_n_n_q <= ~any_src & (release_now | system_reset_n_n_q);
      restart_load_q <= release_now | (wake_accept & (ev_wdt_wake | ev_irq_wake));
      if (release_now) begin
        restart_addr_q <= trap_pend_q ? VEC_CLOCK_FAIL : VEC_RESET;
      end else if (wake_accept && ev_wdt_wake) begin
        restart_addr_q <= cpu.pc + PC_STEP;
      end else if (wake_accept && ev_irq_wake) begin
        restart_addr_q <= cpu.irq_vector;
      end
      clk_fail_trap_q <= trap_fire;
      if (trap_fire) begin
        clock_sel_q <= OSC_GROUP_FAST_RC;
      end else if (state_q == ST_RESET && pwr_seq_q) begin
        clock_sel_q <= cfg.osc_group_select_cfg;
      end
      ost_start_q <= (ev[SRC_POR] | ev[SRC_BOR]) & cfg.crystal_mode;
    end
  end

  assign system_reset_n = system_reset_n_n_q;
  assign restart_load = restart_load_q;
  assign restart_addr = restart_addr_q;
  assign clock_fail_trap = clk_fail_trap_q;
  assign clock_select = clock_sel_q;
  assign osc_startup_start = ost_start_q;

  // Register decode and read multiplexer; unmapped offsets read zero.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign reg_wr = avs_write & ack_q;
  assign reg_idx = avs_address[3:2];
  assign sel_flags = reg_idx == IDX_FLAGS;
  assign sel_osc = reg_idx == IDX_OSC;
  assign sel_seq = reg_idx == IDX_SEQ;
  assign osc_stat = {1'b0, clock_sel_q, 6'h00, clk_s.pll_locked, 1'b0, cf_q, 3'h0};
  assign seq_stat = {cnt_q, 11'h000, cpu_frozen, system_reset_n_n_q, state_q};
  assign rd_mux = sel_flags ? {16'h0000, flags_q} :
                  sel_osc ? {16'h0000, osc_stat} :
                  sel_seq ? seq_stat : 32'h00000000;
  assign avs_readdata = readdata_q;

  // One wait cycle per access; read data is captured while waitrequest is high.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read && !ack_q) begin
        readdata_q <= rd_mux;
      end
    end
  end

  sequence s_q1_wait;
    (state_q == ST_Q1) [*1] ##1 (state_q == ST_RUN);
  endsequence

  property p_pin_never_driven;
    @(posedge sys_clk) disable iff (!rst_n) !master_clear_pin_oe && !master_clear_pin_o;
  endproperty
  a_pin_never_driven: assert property (p_pin_never_driven) else $error("pin driven");

  property p_por_flags;
    @(posedge sys_clk) disable iff (!rst_n)
      ev[SRC_POR] |=> flags_q == FLAGS_POR_VAL;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

  property p_bor_flags;
    @(posedge sys_clk) disable iff (!rst_n)
      (ev[SRC_BOR] && !ev[SRC_POR]) |=> (flags_q[F_BOR] && !flags_q[F_POR]
                                       && flags_q[F_TRAP] == $past(flags_q[F_TRAP]));
  endproperty
  a_bor_flags: assert property (p_bor_flags) else $error("brown-out flags wrong");

  property p_src_holds_reset;
    @(posedge sys_clk) disable iff (!rst_n)
      any_src |=> (!system_reset_n && state_q == ST_RESET);
  endproperty
  a_src_holds_reset: assert property (p_src_holds_reset) else $error("reset not held");

  property p_release_on_q1;
    @(posedge sys_clk) disable iff (!rst_n)
      $rose(system_reset_n) |-> (q_phase_q == Q_FIRST && restart_load && $past(state_q) == ST_Q1);
  endproperty
  a_release_on_q1: assert property (p_release_on_q1) else $error("release off phase");

  property p_trap_vector;
    @(posedge sys_clk) disable iff (!rst_n)
      (clock_fail_trap && !any_src) ##1 s_q1_wait |-> ##[0:4] (restart_addr == VEC_CLOCK_FAIL);
  endproperty
  a_trap_vector: assert property (p_trap_vector) else $error("trap vector wrong");

  property p_trap_frc;
    @(posedge sys_clk) disable iff (!rst_n)
      clock_fail_trap |-> (clock_select == OSC_GROUP_FAST_RC && $past(cfg.clock_fail_monitor_en));
  endproperty
  a_trap_frc: assert property (p_trap_frc) else $error("trap without fast RC");

  property p_frozen_no_release;
    @(posedge sys_clk) disable iff (!rst_n)
      (cpu_frozen && !clk_ok) |=> (!system_reset_n && !clock_fail_trap);
  endproperty
  a_frozen_no_release: assert property (p_frozen_no_release) else $error("left frozen state");

  property p_wdt_wake_resume;
    @(posedge sys_clk) disable iff (!rst_n)
      (wake_accept && ev_wdt_wake) |=> (system_reset_n && restart_load
                                       && restart_addr == $past(cpu.pc) + PC_STEP);
  endproperty
  a_wdt_wake_resume: assert property (p_wdt_wake_resume) else $error("wake not resumed");

  property p_bias_before_power_up_timer;
    @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_BIAS && state_d == ST_POWER_UP_TIMER) |-> (slow_tick && cnt_q == BIAS_TICKS - CNT_W'(1));
  endproperty
  a_bias_before_power_up_timer: assert property (p_bias_before_power_up_timer) else $error("bias delay short");
endmodule
